/* File: tb/fp_quad_load_decode_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module fp_quad_load_decode_tb_top
    import fqld_pkg::*;
;
    logic clock, reset_n, insnValid, insnReady, insnIllegal, memReqValid, memRespValid;
    logic statusWrite, crField0Write, done;
    logic [31:0] insn, gprDataA, gprDataB, memReqAddr;
    logic [4:0] gprRdA, gprRdB;
    logic [63:0] memRespData;
    fqld_fpr_wr_t fprWrite;
    fqld_gpr_wr_t gprWrite;
    logic [31:0] gpr [32];
    logic [31:0] bad [4] = '{32'he000_0001, 32'he400_0002, 32'h7c00_04ae, 32'hc800_0000};
    int err_total, comparisons, i;

    fqld_unit i_fqld_unit (.clock(clock), .reset_n(reset_n), .insnValid(insnValid), .insn(insn),
        .insnReady(insnReady), .insnIllegal(insnIllegal), .gprRdA(gprRdA), .gprRdB(gprRdB),
        .gprDataA(gprDataA), .gprDataB(gprDataB), .memReqValid(memReqValid), .memReqAddr(memReqAddr),
        .memRespValid(memRespValid), .memRespData(memRespData), .fprWrite(fprWrite),
        .gprWrite(gprWrite), .statusWrite(statusWrite), .crField0Write(crField0Write), .done(done));
    fqld_mem_model i_fqld_mem_model (.clock(clock), .reset_n(reset_n), .memReqValid(memReqValid),
        .memReqAddr(memReqAddr), .memRespValid(memRespValid), .memRespData(memRespData));

    // ------------------------------------------------------------
    // Clock, register file, watchdog
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(negedge clock) begin
        gprDataA <= gpr[gprRdA];
        gprDataB <= gpr[gprRdB];
    end
    initial begin
        #100000;
        err_total++;
        $display("ERROR at %0t: watchdog expired", $time);
        wrap_up();
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk_val(input logic [63:0] got, input logic [63:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic logic [31:0] mk(int f, logic [4:0] ft, logic [4:0] ra, logic [4:0] rb, logic [13:0] ds);
        case (f)
            0: mk = {FQLD_OP_QUAD_IMM, ft, ra, ds, FQLD_IMM_TAIL};
            1: mk = {FQLD_OP_QUAD_IMM_UPD, ft, ra, ds, FQLD_IMM_TAIL};
            2: mk = {FQLD_OP_EXT, ft, ra, rb, FQLD_XOP_QUAD_IDX_UPD, ds[0]};
            default: mk = {FQLD_OP_EXT, ft, ra, rb, FQLD_XOP_QUAD_IDX, ds[0]};
        endcase
    endfunction
    function automatic logic [31:0] exp_ea(logic [31:0] w);
        logic [31:0] base;
        base = (w[20:16] == 5'h00) ? 32'h0 : gpr[w[20:16]];
        if (w[31:26] == 6'h1f)
            exp_ea = base + gpr[w[15:11]];
        else
            exp_ea = base + {{16{w[15]}}, w[15:2], 2'h0};
    endfunction
    task automatic wait_ready();
        for (int k = 0; k < 50 && insnReady !== 1'b1; k++) @(negedge clock);
        chk_flag(insnReady, 1'b1, "ready");
    endtask
    task automatic run_insn(input logic [31:0] w);
        logic [31:0] ea;
        logic [31:0] cur;
        logic upd, gw, fin;
        int nf, nm;
        ea = exp_ea(w);
        upd = (w[31:26] == 6'h39) || (w[31:26] == 6'h1f && w[10:1] == 10'h337);
        gw = 1'b0;
        fin = 1'b0;
        nf = 0;
        nm = 0;
        wait_ready();
        insnValid = 1'b1;
        insn = w;
        @(negedge clock);
        insnValid = 1'b0;
        insn = $urandom;
        for (int k = 0; k < 80 && !fin; k++) begin
            if (k == 0) begin
                chk_val({gprRdA, gprRdB}, {w[20:16], w[15:11]}, "gpr index");
            end
            chk_flag(statusWrite | crField0Write, 1'b0, "status");
            if (memReqValid === 1'b1) begin
                chk_val(memReqAddr, 32'(ea + 32'(8 * nm)), "addr");
                nm++;
            end
            if (fprWrite.valid === 1'b1) begin
                cur = 32'(ea + 32'(8 * nf));
                chk_val(fprWrite.num, 5'(w[25:21] + 5'(nf)), "fpr num");
                chk_val(fprWrite.data, {cur ^ 32'ha5a5_0000, ~cur}, "data");
                nf++;
            end
            if (gprWrite.valid === 1'b1) begin
                gw = 1'b1;
                chk_val({gprWrite.num, gprWrite.data}, {w[20:16], ea}, "update");
            end
            fin = (done === 1'b1);
            @(negedge clock);
        end
        chk_val({fin, 15'(nf), 16'(nm)}, {1'b1, 15'd2, 16'd2}, "pair");
        chk_flag(gw, upd && w[20:16] != 5'h00, "writeback");
        if (gw) gpr[w[20:16]] = ea;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h5bd63811));
        reset_n = 1'b0;
        insnValid = 1'b0;
        insn = 32'h0;
        gprDataA = 32'h0;
        gprDataB = 32'h0;
        for (i = 0; i < 32; i++) gpr[i] = $urandom;
        repeat (4) @(negedge clock);
        reset_n = 1'b1;
        @(negedge clock);
        for (i = 0; i < 4; i++) begin
            run_insn(mk(i, 5'h1f, 5'h00, 5'($urandom), 14'($urandom)));
        end
        for (i = 0; i < 4; i++) begin
            run_insn(mk(i, 5'($urandom), 5'h03, 5'h00, 14'h2001));
        end
        for (i = 0; i < 48; i++) run_insn(mk(i % 4, 5'($urandom), 5'($urandom), 5'($urandom), 14'($urandom)));
        foreach (bad[j]) begin
            wait_ready();
            insnValid = 1'b1;
            insn = bad[j];
            @(negedge clock);
            chk_flag(insnIllegal, 1'b1, "illegal");
            insnValid = 1'b0;
            repeat (4) begin
                @(negedge clock);
                chk_flag(memReqValid | insnIllegal, 1'b0, "dropped");
            end
        end
        wrap_up();
    end
endmodule
`default_nettype wire

/* File: tb/fqld_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fqld_mem_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic memReqValid,
    input wire logic [31:0] memReqAddr,
    output var logic memRespValid,
    output var logic [63:0] memRespData
);
    // ------------------------------------------------------------
    // One answer per request, 1 to 5 cycles late
    // ------------------------------------------------------------
    logic [31:0] addr;
    int lat;
    initial begin
        memRespValid = 1'b0;
        memRespData = 64'h0;
        forever begin
            @(posedge clock);
            if (reset_n === 1'b1 && memReqValid === 1'b1) begin
                addr = memReqAddr;
                lat = $urandom_range(5, 1);
                repeat (lat) @(negedge clock);
                memRespValid = 1'b1;
                memRespData = {addr ^ 32'ha5a5_0000, ~addr};
                @(negedge clock);
                memRespValid = 1'b0;
                memRespData = ~memRespData;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verilog/fqld_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
module fqld_decoder
    import fqld_pkg::*;
(
    input wire logic [31:0] insn,
    output fqld_dec_t dec
);
    // ------------------------------------------------------------
    // Field split and form recognition
    // ------------------------------------------------------------
    logic [5:0] primary;
    logic [9:0] extended;

    always_comb begin
        primary = insn[31:26];
        extended = insn[10:1];
        dec.firstTargetFpr = insn[25:21];
        dec.baseGpr = insn[20:16];
        dec.indexGpr = insn[15:11];
        dec.scaledDisplacement = insn[15:2];
        dec.recordBit = insn[0];
        dec.form = FQLD_FORM_NONE;
        if (primary == FQLD_OP_QUAD_IMM && insn[1:0] == FQLD_IMM_TAIL) begin
            dec.form = FQLD_FORM_IMM;
        end else if (primary == FQLD_OP_QUAD_IMM_UPD && insn[1:0] == FQLD_IMM_TAIL) begin
            dec.form = FQLD_FORM_IMM_UPD;
        end else if (primary == FQLD_OP_EXT && extended == FQLD_XOP_QUAD_IDX_UPD) begin
            dec.form = FQLD_FORM_IDX_UPD;
        end else if (primary == FQLD_OP_EXT && extended == FQLD_XOP_QUAD_IDX) begin
            dec.form = FQLD_FORM_IDX;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/fqld_pkg.sv */
`default_nettype none
package fqld_pkg;

    // ------------------------------------------------------------
    // Instruction fields (bit 31 is the most significant bit)
    // ------------------------------------------------------------
    localparam int FQLD_INSN_W = 32;
    localparam int FQLD_ADDR_W = 32;
    localparam int FQLD_DATA_W = 64;
    localparam int FQLD_REG_W = 5;
    localparam int FQLD_DS_W = 14;
    localparam int FQLD_OFS_HI_W = 30;

    localparam logic [5:0] FQLD_OP_QUAD_IMM = 6'h38;
    localparam logic [5:0] FQLD_OP_QUAD_IMM_UPD = 6'h39;
    localparam logic [5:0] FQLD_OP_EXT = 6'h1f;
    localparam logic [9:0] FQLD_XOP_QUAD_IDX_UPD = 10'h337;
    localparam logic [9:0] FQLD_XOP_QUAD_IDX = 10'h317;
    localparam logic [1:0] FQLD_IMM_TAIL = 2'h0;
    localparam logic [1:0] FQLD_OFS_LOW = 2'h0;

    localparam logic [4:0] FQLD_REG_ZERO = 5'h00;
    localparam logic [4:0] FQLD_REG_LAST = 5'h1f;
    localparam logic [4:0] FQLD_REG_STEP = 5'h01;
    localparam logic [31:0] FQLD_DW_BYTES = 32'h0000_0008;

    typedef enum logic [2:0] {
        FQLD_FORM_NONE,
        FQLD_FORM_IMM,
        FQLD_FORM_IMM_UPD,
        FQLD_FORM_IDX_UPD,
        FQLD_FORM_IDX
    } fqld_form_t;

    typedef struct packed {
        fqld_form_t form;
        logic [4:0] firstTargetFpr;
        logic [4:0] baseGpr;
        logic [4:0] indexGpr;
        logic [13:0] scaledDisplacement;
        logic recordBit;
    } fqld_dec_t;

    typedef struct packed {
        logic valid;
        logic [4:0] num;
        logic [63:0] data;
    } fqld_fpr_wr_t;

    typedef struct packed {
        logic valid;
        logic [4:0] num;
        logic [31:0] data;
    } fqld_gpr_wr_t;

endpackage
`default_nettype wire

/* File: verilog/fqld_unit.sv */
`timescale 1ns/10ps
`default_nettype none
module fqld_unit
    import fqld_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic insnValid,
    input wire logic [31:0] insn,
    output logic insnReady,
    output logic insnIllegal,
    output logic [4:0] gprRdA,
    output logic [4:0] gprRdB,
    input wire logic [31:0] gprDataA,
    input wire logic [31:0] gprDataB,
    output logic memReqValid,
    output logic [31:0] memReqAddr,
    input wire logic memRespValid,
    input wire logic [63:0] memRespData,
    output fqld_fpr_wr_t fprWrite,
    output fqld_gpr_wr_t gprWrite,
    output logic statusWrite,
    output logic crField0Write,
    output logic done
);
    // ------------------------------------------------------------
    // Address and target register helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] imm_offset(input logic [13:0] ds);
        logic [29:0] ext;
        ext = {{(FQLD_OFS_HI_W - FQLD_DS_W){ds[FQLD_DS_W-1]}}, ds};
        return {ext, FQLD_OFS_LOW};
    endfunction

    function automatic logic [4:0] next_fpr(input logic [4:0] num);
        return (num == FQLD_REG_LAST) ? FQLD_REG_ZERO : 5'(num + FQLD_REG_STEP);
    endfunction

    typedef enum {
        FQLD_IDLE,
        FQLD_ADDR,
        FQLD_REQ0,
        FQLD_WAIT0,
        FQLD_REQ1,
        FQLD_WAIT1,
        FQLD_DONE
    } fqld_state_t;

    fqld_dec_t decNow;
    fqld_dec_t dec_r;
    fqld_state_t state_r;
    logic [31:0] ea_r;
    logic [31:0] eaNxt;
    logic isUpdate;

    fqld_decoder decoder (
        .insn(insn),
        .dec(decNow)
    );

    assign isUpdate = (dec_r.form == FQLD_FORM_IMM_UPD) || (dec_r.form == FQLD_FORM_IDX_UPD);

    // ------------------------------------------------------------
    // Effective address
    // ------------------------------------------------------------
    always_comb begin
        if (dec_r.form == FQLD_FORM_IMM || dec_r.form == FQLD_FORM_IMM_UPD) begin
            eaNxt = (dec_r.baseGpr == FQLD_REG_ZERO) ? imm_offset(dec_r.scaledDisplacement)
                : 32'(gprDataA + imm_offset(dec_r.scaledDisplacement));
        end else begin
            eaNxt = (dec_r.baseGpr == FQLD_REG_ZERO) ? gprDataB
                : 32'(gprDataA + gprDataB);
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= FQLD_IDLE;
            dec_r <= '0;
            ea_r <= '0;
        end else begin
            case (state_r)
                FQLD_IDLE: begin
                    if (insnValid && decNow.form != FQLD_FORM_NONE) begin
                        dec_r <= decNow;
                        state_r <= FQLD_ADDR;
                    end
                end
                FQLD_ADDR: begin
                    ea_r <= eaNxt;
                    state_r <= FQLD_REQ0;
                end
                FQLD_REQ0: state_r <= FQLD_WAIT0;
                FQLD_WAIT0: begin
                    if (memRespValid) begin
                        state_r <= FQLD_REQ1;
                    end
                end
                FQLD_REQ1: state_r <= FQLD_WAIT1;
                FQLD_WAIT1: begin
                    if (memRespValid) begin
                        state_r <= FQLD_DONE;
                    end
                end
                FQLD_DONE: state_r <= FQLD_IDLE;
                default: state_r <= FQLD_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Handshake and memory request outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            insnReady <= 1'b0;
            insnIllegal <= 1'b0;
            memReqValid <= 1'b0;
            memReqAddr <= '0;
            gprRdA <= '0;
            gprRdB <= '0;
            done <= 1'b0;
        end else begin
            insnReady <= (state_r == FQLD_IDLE) && !(insnValid && decNow.form != FQLD_FORM_NONE)
                || (state_r == FQLD_DONE);
            insnIllegal <= (state_r == FQLD_IDLE) && insnValid && insnReady && decNow.form == FQLD_FORM_NONE;
            memReqValid <= (state_r == FQLD_ADDR) || (state_r == FQLD_WAIT0 && memRespValid);
            if (state_r == FQLD_ADDR) begin
                memReqAddr <= eaNxt;
            end else if (state_r == FQLD_WAIT0 && memRespValid) begin
                memReqAddr <= 32'(ea_r + FQLD_DW_BYTES);
            end
            if (state_r == FQLD_IDLE && insnValid) begin
                gprRdA <= decNow.baseGpr;
                gprRdB <= decNow.indexGpr;
            end
            done <= (state_r == FQLD_WAIT1) && memRespValid;
        end
    end

    // ------------------------------------------------------------
    // Register file writes
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fprWrite <= '0;
            gprWrite <= '0;
            statusWrite <= 1'b0;
            crField0Write <= 1'b0;
        end else begin
            fprWrite.valid <= 1'b0;
            gprWrite.valid <= 1'b0;
            statusWrite <= 1'b0;
            crField0Write <= 1'b0;
            if (state_r == FQLD_WAIT0 && memRespValid) begin
                fprWrite.valid <= 1'b1;
                fprWrite.num <= dec_r.firstTargetFpr;
                fprWrite.data <= memRespData;
            end else if (state_r == FQLD_WAIT1 && memRespValid) begin
                fprWrite.valid <= 1'b1;
                fprWrite.num <= next_fpr(dec_r.firstTargetFpr);
                fprWrite.data <= memRespData;
                if (isUpdate && dec_r.baseGpr != FQLD_REG_ZERO) begin
                    gprWrite.valid <= 1'b1;
                    gprWrite.num <= dec_r.baseGpr;
                    gprWrite.data <= ea_r;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_no_status_write: assert property (@(posedge clock) disable iff (!reset_n)
        !statusWrite && !crField0Write) else $error("status or cr0 written");
    a_second_addr_step: assert property (@(posedge clock) disable iff (!reset_n)
        (state_r == FQLD_WAIT0 && memRespValid) |=> memReqValid && memReqAddr == 32'($past(ea_r) + FQLD_DW_BYTES))
        else $error("second address not ea plus eight");
    a_wrap_target: assert property (@(posedge clock) disable iff (!reset_n)
        (state_r == FQLD_WAIT1 && memRespValid && dec_r.firstTargetFpr == FQLD_REG_LAST)
        |=> fprWrite.num == FQLD_REG_ZERO) else $error("target did not wrap");
    a_first_target: assert property (@(posedge clock) disable iff (!reset_n)
        (state_r == FQLD_WAIT0 && memRespValid) |=> fprWrite.valid && fprWrite.num == $past(dec_r.firstTargetFpr))
        else $error("first target wrong");
    a_update_base: assert property (@(posedge clock) disable iff (!reset_n)
        gprWrite.valid |-> gprWrite.num != FQLD_REG_ZERO && gprWrite.data == ea_r && isUpdate)
        else $error("bad base update");
    a_no_plain_update: assert property (@(posedge clock) disable iff (!reset_n)
        (dec_r.form == FQLD_FORM_IDX || dec_r.form == FQLD_FORM_IMM) |-> !gprWrite.valid)
        else $error("plain form updated base");
    a_imm_zero_base: assert property (@(posedge clock) disable iff (!reset_n)
        (state_r == FQLD_ADDR && dec_r.baseGpr == FQLD_REG_ZERO && dec_r.form == FQLD_FORM_IMM)
        |=> memReqAddr == {{16{$past(dec_r.scaledDisplacement[13])}}, $past(dec_r.scaledDisplacement), FQLD_OFS_LOW})
        else $error("imm address wrong");
    a_idx_address: assert property (@(posedge clock) disable iff (!reset_n)
        (state_r == FQLD_ADDR && dec_r.baseGpr != FQLD_REG_ZERO && dec_r.form == FQLD_FORM_IDX)
        |=> memReqAddr == 32'($past(gprDataA) + $past(gprDataB)))
        else $error("indexed address wrong");
    a_decode_upd: assert property (@(posedge clock) disable iff (!reset_n)
        (state_r == FQLD_IDLE && insnValid && insn[31:26] == FQLD_OP_QUAD_IMM_UPD && insn[1:0] == FQLD_IMM_TAIL)
        |=> dec_r.form == FQLD_FORM_IMM_UPD) else $error("update form missed");
endmodule
`default_nettype wire
